// ===== verilog/rcif_pkg.sv
// Purpose: Constants for the render context image formatter.
// Assumes: One engine clock, dword-wide image stream.
// Notes:   Dword indices are image positions, byte address is four times.
package rcif_pkg;
  localparam int unsigned IMG_DWORDS      = 100;
  localparam int unsigned BASE_ALIGN_BITS = 8;
  localparam logic [2:0]  MI_TYPE         = 3'h0;
  localparam logic [5:0]  LRI_OPCODE      = 6'h22;
  localparam logic [3:0]  BYTE_SUPPRESS   = 4'hf;
  localparam logic [5:0]  LRI_LENGTH      = 6'h2b;
  localparam logic [2:0]  PIPE_TYPE       = 3'h3;
  localparam logic [6:0]  IDX_CNT_BASE    = 7'h0a;
  localparam logic [6:0]  IDX_PIPE_SEL    = 7'h30;
  localparam logic [6:0]  IDX_RB_SIZE     = 7'h32;
  localparam logic [6:0]  IDX_CONST_BUF   = 7'h36;
  localparam logic [6:0]  IDX_SIP         = 7'h3f;
  localparam logic [6:0]  IDX_DEPTH_DESC  = 7'h45;
  localparam logic [6:0]  IDX_DEPTH_SIZE  = 7'h47;
  localparam logic [6:0]  IDX_BLEND_RED   = 7'h5a;
  localparam logic [6:0]  IDX_CLAMP       = 7'h5f;
  localparam logic [6:0]  IDX_LINE_MASK   = 7'h63;
  localparam int unsigned COUNTERS        = 9;
endpackage

// ===== verilog/rcif_fifo.sv
// Purpose: Synchronous valid/ready FIFO for image dwords.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Depth must be a power of two.
`timescale 1ns/100ps
`default_nettype none
module rcif_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             en_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  // Pointer wrap logic only works for power-of-two depths.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      wp_d;
  logic [AW:0]      rp_q;
  logic [AW:0]      rp_d;
  logic             push;
  logic             pop;
  // Full when pointers differ only in the wrap bit.
  assign in_ready_o  = !((wp_q[AW] != rp_q[AW]) &&
                         (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid_o = (wp_q != rp_q);
  assign out_data_o  = mem_q[rp_q[AW-1:0]];
  assign push        = en_i && in_valid_i && in_ready_o;
  assign pop         = en_i && out_valid_o && out_ready_i;
  // Pointer advance.
  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end
  // Storage has no reset; only the pointers need one.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      if (push) begin
        mem_q[wp_q[AW-1:0]] <= in_data_i;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/rcif_restore.sv
// Purpose: Applies byte suppression of a restored register-load header.
// Assumes: Combinational merge, caller registers the result.
// Notes:   Bit 0 of the mask guards data bits 7:0.
`timescale 1ns/100ps
`default_nettype none
module rcif_restore (
  input  wire logic [31:0] old_i,
  input  wire logic [31:0] new_i,
  input  wire logic [3:0]  suppress_i,
  output logic      [31:0] merged_o
);
  // Each set mask bit keeps the old byte.
  for (genvar b = 0; b < 4; b++) begin : g_byte
    assign merged_o[8*b +: 8] = suppress_i[b] ? old_i[8*b +: 8]
                                              : new_i[8*b +: 8];
  end
endmodule
`default_nettype wire

// ===== verilog/rcif_formatter.sv
// Purpose: Streams the register/state context image as dword writes.
// Assumes: Live state is presented stable on inputs during a save.
// Notes:   Media state after the line mask is not produced here.
`timescale 1ns/100ps
`default_nettype none
module rcif_formatter #(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        en_i,
  input  wire logic        save_start_i,
  input  wire logic [31:0] ctx_base_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             align_err_o,
  input  wire logic [31:0] cache0_addr_i,
  input  wire logic [31:0] cache0_data_i,
  input  wire logic [31:0] cache1_addr_i,
  input  wire logic [31:0] cache1_data_i,
  input  wire logic [31:0] arb_addr_i,
  input  wire logic [31:0] arb_data_i,
  input  wire logic [31:0] instr_ctl_addr_i,
  input  wire logic [31:0] instr_ctl_data_i,
  input  wire logic [31:0] cnt_addr_base_i,
  input  wire logic [63:0] cnt_value_i [rcif_pkg::COUNTERS],
  input  wire logic        media_pipe_i,
  input  wire logic [4:0]  rb_alloc_size_i,
  input  wire logic [2:0]  rb_entries_i,
  input  wire logic [5:0]  fence_modify_i,
  input  wire logic [9:0]  fence_i [6],
  input  wire logic [25:0] cbuf_start_i,
  input  wire logic [5:0]  cbuf_len_i,
  input  wire logic [19:0] base_addr_i [5],
  input  wire logic [4:0]  base_modify_i,
  input  wire logic [27:0] sip_i,
  input  wire logic [15:0] rect_i [6],
  input  wire logic [31:0] depth_desc_i,
  input  wire logic [31:0] depth_base_i,
  input  wire logic [31:0] depth_size_i,
  input  wire logic [31:0] depth_array_i,
  input  wire logic [31:0] key_lo_i [4],
  input  wire logic [31:0] key_hi_i [4],
  input  wire logic [31:0] blend_i [4],
  input  wire logic [31:0] clamp_i,
  input  wire logic [4:0]  poly_x_i,
  input  wire logic [4:0]  poly_y_i,
  input  wire logic [8:0]  line_repeat_i,
  input  wire logic [3:0]  line_index_i,
  input  wire logic [15:0] line_pattern_i,
  input  wire logic [15:0] line_inv_repeat_i,
  input  wire logic        rest_valid_i,
  input  wire logic [31:0] rest_hdr_i,
  input  wire logic [31:0] rest_old_i,
  input  wire logic [31:0] rest_new_i,
  output logic      [31:0] rest_data_o,
  output logic             mem_valid_o,
  input  wire logic        mem_ready_i,
  output logic      [31:0] mem_addr_o,
  output logic      [31:0] mem_data_o
);
  // The buffer needs a power-of-two depth of at least two.
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("FIFO depth not supported");
  end

  typedef enum logic [2:0] {
    RCIF_IDLE = 3'b001,
    RCIF_EMIT = 3'b010,
    RCIF_DRAIN = 3'b100
  } rcif_state_type;

  // Builds a pipeline header from subcodes and length.
  function automatic logic [31:0] rcif_hdr(input logic [1:0] pipe,
                                           input logic [2:0] op,
                                           input logic [7:0] sub,
                                           input logic [7:0] len);
    rcif_hdr = {rcif_pkg::PIPE_TYPE, pipe, op, sub, 8'h00, len};
  endfunction

  // Packs a base-address dword with its modify flag.
  function automatic logic [31:0] rcif_base(input logic [19:0] a,
                                            input logic m);
    rcif_base = {a, 11'h000, m};
  endfunction

  rcif_state_type  st_q;
  rcif_state_type  st_d;
  logic [6:0]      idx_q;
  logic [6:0]      idx_d;
  logic [31:0]     addr_q;
  logic [31:0]     addr_d;
  logic            done_q;
  logic            done_d;
  logic            err_q;
  logic            err_d;
  logic [31:0]     rest_q;
  logic [31:0]     rest_d;
  logic [31:0]     merged;
  logic [31:0]     word;
  logic            push;
  logic            f_ready;
  logic [63:0]     fo_data;
  logic [6:0]      cnt_rel;
  logic [31:0]     cnt_addr;
  logic [63:0]     cnt_val;

  assign push   = (st_q == RCIF_EMIT) && f_ready;
  assign busy_o = (st_q != RCIF_IDLE);
  assign done_o = done_q;
  assign align_err_o = err_q;

  // Counter slot selection; 64-bit registers sit eight bytes apart.
  assign cnt_rel  = idx_q - rcif_pkg::IDX_CNT_BASE;
  assign cnt_val  = cnt_value_i[cnt_rel[5:2]];
  assign cnt_addr = cnt_addr_base_i + {25'h000_0000, cnt_rel[5:2], 3'h0};

  // Image content by dword index.
  always_comb begin
    word = 32'h0000_0000;
    unique case (idx_q)
      7'h01: word = {rcif_pkg::MI_TYPE, rcif_pkg::LRI_OPCODE, 11'h000,
                     rcif_pkg::BYTE_SUPPRESS, 2'b00,
                     rcif_pkg::LRI_LENGTH};
      7'h02: word = cache0_addr_i;
      7'h03: word = cache0_data_i;
      7'h04: word = cache1_addr_i;
      7'h05: word = cache1_data_i;
      7'h06: word = arb_addr_i;
      7'h07: word = arb_data_i;
      7'h08: word = instr_ctl_addr_i;
      7'h09: word = instr_ctl_data_i;
      7'h30: word = rcif_hdr(2'h0, 3'h1, 8'h04, 8'h00) |
                    {31'h0000_0000, media_pipe_i};
      7'h31: word = rcif_hdr(2'h0, 3'h0, 8'h01, 8'h00);
      7'h32: word = {23'h00_0000, rb_alloc_size_i, 1'b0, rb_entries_i};
      7'h33: word = rcif_hdr(2'h0, 3'h0, 8'h00, 8'h01) |
                    {18'h0_0000, fence_modify_i, 8'h00};
      7'h34: word = {2'b00, fence_i[2], fence_i[1], fence_i[0]};
      7'h35: word = {2'b00, fence_i[5], fence_i[4], fence_i[3]};
      7'h36: word = rcif_hdr(2'h0, 3'h0, 8'h02, 8'h00);
      7'h37: word = {cbuf_start_i, cbuf_len_i};
      7'h38: word = rcif_hdr(2'h0, 3'h1, 8'h01, 8'h04);
      7'h39: word = rcif_base(base_addr_i[0], base_modify_i[0]);
      7'h3a: word = rcif_base(base_addr_i[1], base_modify_i[1]);
      7'h3b: word = rcif_base(base_addr_i[2], base_modify_i[2]);
      7'h3c: word = rcif_base(base_addr_i[3], base_modify_i[3]);
      7'h3d: word = rcif_base(base_addr_i[4], base_modify_i[4]);
      7'h3e: word = rcif_hdr(2'h0, 3'h1, 8'h02, 8'h00);
      7'h3f: word = {sip_i, 4'h0};
      7'h40: word = rcif_hdr(2'h3, 3'h1, 8'h00, 8'h02);
      7'h41: word = {rect_i[1], rect_i[0]};
      7'h42: word = {rect_i[3], rect_i[2]};
      7'h43: word = {rect_i[5], rect_i[4]};
      7'h44: word = rcif_hdr(2'h3, 3'h1, 8'h05, 8'h03);
      7'h45: word = depth_desc_i & 32'hee1f_ffff;
      7'h46: word = depth_base_i;
      7'h47: word = depth_size_i & 32'hffff_fffe;
      7'h48: word = depth_array_i & 32'hffff_f000;
      7'h49, 7'h4d, 7'h51, 7'h55:
             word = rcif_hdr(2'h3, 3'h1, 8'h04, 8'h02);
      7'h4a: word = {2'd0, 30'h0000_0000};
      7'h4e: word = {2'd1, 30'h0000_0000};
      7'h52: word = {2'd2, 30'h0000_0000};
      7'h56: word = {2'd3, 30'h0000_0000};
      7'h4b: word = key_lo_i[0];
      7'h4c: word = key_hi_i[0];
      7'h4f: word = key_lo_i[1];
      7'h50: word = key_hi_i[1];
      7'h53: word = key_lo_i[2];
      7'h54: word = key_hi_i[2];
      7'h57: word = key_lo_i[3];
      7'h58: word = key_hi_i[3];
      7'h59: word = rcif_hdr(2'h3, 3'h1, 8'h01, 8'h03);
      7'h5a: word = blend_i[0];
      7'h5b: word = blend_i[1];
      7'h5c: word = blend_i[2];
      7'h5d: word = blend_i[3];
      7'h5e: word = rcif_hdr(2'h3, 3'h1, 8'h09, 8'h00);
      7'h5f: word = clamp_i;
      7'h60: word = rcif_hdr(2'h3, 3'h1, 8'h06, 8'h00);
      7'h61: word = {19'h0_0000, poly_x_i, 3'h0, poly_y_i};
      7'h62: word = rcif_hdr(2'h3, 3'h1, 8'h08, 8'h01);
      7'h63: word = {1'b1, 1'b0, line_repeat_i, 1'b0,
                     line_index_i, line_pattern_i};
      // Second line mask payload; the repeat count shows again low.
      7'h64: word = {line_inv_repeat_i, 7'h00, line_repeat_i};
      default: begin
        if (idx_q >= rcif_pkg::IDX_CNT_BASE && idx_q <= 7'h29) begin
          unique case (idx_q[1:0] ^ 2'b10)
            2'b00: word = cnt_addr;
            2'b01: word = cnt_val[31:0];
            2'b10: word = cnt_addr + 32'h0000_0004;
            default: word = cnt_val[63:32];
          endcase
        end
        if (idx_q >= 7'h2a && idx_q <= 7'h2d) begin
          unique case (idx_q[1:0] ^ 2'b10)
            2'b00: word = cnt_addr;
            2'b01: word = cnt_val[31:0];
            2'b10: word = cnt_addr + 32'h0000_0004;
            default: word = cnt_val[63:32];
          endcase
        end
      end
    endcase
  end

  // Sequencer: advances one dword per accepted push.
  always_comb begin
    st_d   = st_q;
    idx_d  = idx_q;
    addr_d = addr_q;
    done_d = 1'b0;
    err_d  = err_q;
    unique case (st_q)
      RCIF_IDLE: begin
        if (save_start_i) begin
          err_d = (ctx_base_i[rcif_pkg::BASE_ALIGN_BITS-1:0] != 8'h00);
          if (!err_d) begin
            st_d   = RCIF_EMIT;
            idx_d  = 7'h00;
            addr_d = ctx_base_i;
          end
        end
      end
      RCIF_EMIT: begin
        if (push) begin
          idx_d  = idx_q + 7'h01;
          addr_d = addr_q + 32'h0000_0004;
          if (idx_q == rcif_pkg::IDX_LINE_MASK + 7'h01) begin
            st_d = RCIF_DRAIN;
          end
        end
      end
      RCIF_DRAIN: begin
        if (!mem_valid_o) begin
          st_d   = RCIF_IDLE;
          done_d = 1'b1;
        end
      end
      default: st_d = RCIF_IDLE;
    endcase
  end

  // Restore path: suppression mask from the header bits 11:8.
  rcif_restore u_restore (
    .old_i      (rest_q),
    .new_i      (rest_new_i),
    .suppress_i (rest_hdr_i[11:8]),
    .merged_o   (merged)
  );
  always_comb begin
    rest_d = rest_q;
    if (rest_valid_i) begin
      rest_d = (rest_old_i & 32'h0000_0000) | merged;
    end
  end
  assign rest_data_o = rest_q;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q   <= RCIF_IDLE;
      idx_q  <= 7'h00;
      addr_q <= 32'h0000_0000;
      done_q <= 1'b0;
      err_q  <= 1'b0;
      rest_q <= 32'h0000_0000;
    end else if (en_i) begin
      st_q   <= st_d;
      idx_q  <= idx_d;
      addr_q <= addr_d;
      done_q <= done_d;
      err_q  <= err_d;
      rest_q <= rest_d;
    end
  end

  // Address and data travel together so back-pressure keeps them paired.
  rcif_fifo #(
    .WIDTH (64),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .en_i        (en_i),
    .in_data_i   ({addr_q, word}),
    .in_valid_i  (st_q == RCIF_EMIT &&
                  idx_q <= rcif_pkg::IDX_LINE_MASK + 7'h01),
    .in_ready_o  (f_ready),
    .out_data_o  (fo_data),
    .out_valid_o (mem_valid_o),
    .out_ready_i (mem_ready_i)
  );
  assign mem_addr_o = fo_data[63:32];
  assign mem_data_o = fo_data[31:0];

  a_hdr_fixed: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (push && idx_q == 7'h01) |-> (word == 32'h1100_0f2b))
    else $error("register-load header wrong");
  a_addr_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (push && en_i && idx_q != 7'h64) |=>
      (addr_q == $past(addr_q) + 32'h0000_0004))
    else $error("address did not step by four");
  a_align_ok: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == RCIF_EMIT) |-> (addr_q[7:0] == {idx_q[5:0], 2'b00}))
    else $error("image base not aligned");
  a_const_inv: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (idx_q == rcif_pkg::IDX_CONST_BUF) |-> !word[8])
    else $error("constant buffer valid saved set");
  a_sip_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (idx_q == rcif_pkg::IDX_SIP) |-> (word[3:0] == 4'h0))
    else $error("instruction pointer low bits set");
  a_pipe_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (idx_q == rcif_pkg::IDX_PIPE_SEL) |->
      (word == {16'h6104, 15'h0000, media_pipe_i}))
    else $error("pipeline select wrong");
  a_rb_size: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (idx_q == rcif_pkg::IDX_RB_SIZE) |->
      (word[31:9] == 23'h00_0000 && !word[3]))
    else $error("return buffer reserved bits set");
  a_clamp_eq: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (idx_q == rcif_pkg::IDX_CLAMP) |-> (word == clamp_i))
    else $error("clamp dword wrong");
endmodule
`default_nettype wire

// ===== tb/rcif_mem_model.sv
// Purpose: Memory side model that takes the context image writes.
// Assumes: Writes are valid/ready beats of one dword and address.
// Notes:   Slow mode stalls about three beats in four to fill the FIFO.
`timescale 1ns/100ps
`default_nettype none
module rcif_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        slow_i,
  input  wire logic        valid_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] data_i,
  output logic             ready_o
);
  int          seed = 16197;
  logic [31:0] mem [logic [31:0]];
  // Ready wanders on its own, so a stall can land on any beat.
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= slow_i ? (($random(seed) & 3) == 0)
                        : (($random(seed) & 3) != 0);
    end
    if (rst_b_i && valid_i && ready_o) begin
      mem[addr_i] = data_i;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the context image formatter.
// Assumes: The memory model answers writes with random stalls.
// Notes:   Expected dwords come from a field table kept in the bench.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [31:0] F  = 32'hffff_ffff;
  localparam logic [31:0] H  = 32'he000_0000;
  localparam logic [31:0] HV = 32'h6000_0000;
  logic        clk = 1'b0, rst_b = 1'b0, en = 1'b1, start = 1'b0;
  logic        slow = 1'b0, media = 1'b0, rv = 1'b0, rv_d = 1'b0;
  logic        rdy, busy, done, aerr, mval;
  logic [31:0] base = '0, rh = '0, rn = '0, rmod = '0;
  logic [31:0] maddr, mdata, rdata, dd, db, ds, da, clamp;
  logic [31:0] rg [9], klo [4], khi [4], bl [4];
  logic [63:0] cnt [9];
  logic [9:0]  fen [6];
  logic [19:0] ba [5];
  logic [15:0] rect [6];
  logic [4:0]  rba, bmod, px, py;
  logic [2:0]  rbe;
  logic [5:0]  fmod, clen;
  logic [25:0] cst;
  logic [27:0] system_instruction_pointer;
  logic [8:0]  lrep;
  logic [3:0]  lidx;
  logic [15:0] lpat, lir;
  logic [95:0] wq [$];
  logic [31:0] rq [$];
  logic [95:0] e;
  int          seed = 16197, err_total = 0, checks_done = 0, dones = 0;

  always #10 clk = ~clk;

  rcif_formatter #(.FIFO_DEPTH(8)) u_dut (
    .clk_i(clk), .rst_b_i(rst_b), .en_i(en), .save_start_i(start),
    .ctx_base_i(base), .busy_o(busy), .done_o(done), .align_err_o(aerr),
    .cache0_addr_i(rg[0]), .cache0_data_i(rg[1]), .cache1_addr_i(rg[2]),
    .cache1_data_i(rg[3]), .arb_addr_i(rg[4]), .arb_data_i(rg[5]),
    .instr_ctl_addr_i(rg[6]), .instr_ctl_data_i(rg[7]),
    .cnt_addr_base_i(rg[8]), .cnt_value_i(cnt), .media_pipe_i(media),
    .rb_alloc_size_i(rba), .rb_entries_i(rbe), .fence_modify_i(fmod),
    .fence_i(fen), .cbuf_start_i(cst), .cbuf_len_i(clen),
    .base_addr_i(ba), .base_modify_i(bmod), .sip_i(system_instruction_pointer), .rect_i(rect),
    .depth_desc_i(dd), .depth_base_i(db), .depth_size_i(ds),
    .depth_array_i(da), .key_lo_i(klo), .key_hi_i(khi), .blend_i(bl),
    .clamp_i(clamp), .poly_x_i(px), .poly_y_i(py), .line_repeat_i(lrep),
    .line_index_i(lidx), .line_pattern_i(lpat),
    .line_inv_repeat_i(lir), .rest_valid_i(rv), .rest_hdr_i(rh),
    .rest_old_i(32'h0000_0000), .rest_new_i(rn), .rest_data_o(rdata),
    .mem_valid_o(mval), .mem_ready_i(rdy), .mem_addr_o(maddr),
    .mem_data_o(mdata));

  rcif_mem_model u_mem (
    .clk_i(clk), .rst_b_i(rst_b), .slow_i(slow), .valid_i(mval),
    .addr_i(maddr), .data_i(mdata), .ready_o(rdy));

  task automatic cmp_word(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic cmp_bit(input string nm, input logic x, input logic g);
    cmp_word(nm, {31'h0, x}, {31'h0, g});
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Fresh live state before each save, so no field passes by luck.
  task automatic rnd_state();
    logic [127:0] r;
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    {rba, rbe, fmod, cst, clen, bmod, system_instruction_pointer, px, py, lrep, lidx, lpat} <= r[117:0];
    {dd, db, ds, da} <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    clamp <= $random(seed);
    lir <= 16'($random(seed));
    for (int i = 0; i < 9; i++) begin
      rg[i] <= $random(seed);
      cnt[i] <= {$random(seed), $random(seed)};
      if (i < 6) fen[i] <= 10'($random(seed));
      if (i < 6) rect[i] <= 16'($random(seed));
      if (i < 5) ba[i] <= 20'($random(seed));
      if (i < 4) klo[i] <= $random(seed);
      if (i < 4) khi[i] <= $random(seed);
      if (i < 4) bl[i] <= $random(seed);
    end
  endtask

  // Expected dword and care mask; reserved bits the table leaves open are masked.
  function automatic logic [63:0] exp_word(input int i);
    int k;
    k = (i - 10) / 4;
    case (i)
      0, 8'h2e, 8'h2f: return {32'h0000_0000, F};
      8'h64: return {lir, 7'h00, lrep, F};
      1: return {3'h0, 6'h22, 11'h0, 4'hf, 2'h0, 6'h2b, F};
      8'h30: return {3'h3, 5'h01, 8'h04, 15'h0, media, F};
      8'h32: return {23'h0, rba, 1'b0, rbe, F};
      8'h33: return {3'h3, 15'h0000, fmod, 8'h01, F};
      8'h34: return {2'h0, fen[2], fen[1], fen[0], F};
      8'h35: return {2'h0, fen[5], fen[4], fen[3], F};
      8'h36: return {HV, 32'he000_0100};
      8'h37: return {cst, clen, F};
      8'h3f: return {system_instruction_pointer, 4'h0, F};
      8'h41, 8'h42, 8'h43: return {rect[2*(i-65)+1], rect[2*(i-65)], F};
      8'h45: return {dd & 32'hee1f_ffff, F};
      8'h46: return {db, F};
      8'h47: return {ds & 32'hffff_fffe, F};
      8'h48: return {da & 32'hffff_f000, F};
      8'h5e: return {HV, 32'he000_ffff};
      8'h5f: return {clamp, F};
      8'h61: return {19'h0, px, 3'h0, py, F};
      8'h63: return {2'h2, lrep, 1'b0, lidx, lpat, F};
      8'h31, 8'h38, 8'h3e, 8'h40, 8'h44, 8'h49, 8'h4d, 8'h51, 8'h55,
      8'h59, 8'h60, 8'h62: return {HV, H};
      default: ;
    endcase
    if (i >= 2 && i <= 9) return {rg[i-2], F};
    if (i >= 8'h0a && i <= 8'h2d) begin
      case ((i - 10) % 4)
        0: return {rg[8] + 32'(8*k), F};
        1: return {cnt[k][31:0], F};
        2: return {rg[8] + 32'(8*k+4), F};
        default: return {cnt[k][63:32], F};
      endcase
    end
    if (i >= 8'h39 && i <= 8'h3d) return {ba[i-57], 11'h0, bmod[i-57], F};
    if (i >= 8'h4a && i <= 8'h58 && (i - 74) % 4 == 0)
      return {2'(k-16), 30'h0000_0000, F};
    if (i >= 8'h4b && i <= 8'h58 && (i - 74) % 4 == 1) return {klo[(i-75)/4], F};
    if (i >= 8'h4c && i <= 8'h58 && (i - 74) % 4 == 2) return {khi[(i-76)/4], F};
    if (i >= 8'h5a && i <= 8'h5d) return {bl[i-90], F};
    return 64'h0000_0000_0000_0000;
  endfunction

  task automatic pulse_start();
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask

  // One save: note every dword, start, optionally retry mid-run, await done.
  task automatic run_save(input logic [31:0] b, input logic m, input logic s, input logic again);
    int n;
    logic [63:0] w;
    rnd_state();
    media <= m;
    slow <= s;
    base <= b;
    @(posedge clk);
    for (n = 0; n <= 8'h64; n++) begin
      w = exp_word(n);
      wq.push_back({b + 32'(4*n), w[63:32] & w[31:0], w[31:0]});
    end
    pulse_start();
    if (again) begin
      repeat (20) @(posedge clk);
      cmp_bit("busy", 1'b1, busy);
      pulse_start();
    end
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    cmp_bit("done", 1'b1, done);
    cmp_word("left", 32'h0000_0000, 32'(wq.size()));
    cmp_bit("align_err", 1'b0, aerr);
    @(negedge clk);
    cmp_bit("done_after", 1'b0, done);
  endtask

  // Watcher: every accepted beat takes the oldest note off the queue.
  always @(posedge clk) begin
    if (rst_b && mval && rdy) begin
      if (wq.size() == 0) begin
        err_total++;
        $display("ERROR mem_addr expected none seen %h", maddr);
      end else begin
        e = wq.pop_front();
        cmp_word("mem_addr", e[95:64], maddr);
        cmp_word("mem_data", e[63:32], mdata & e[31:0]);
      end
    end
    if (rv_d) cmp_word("rest_data", rq.pop_front(), rdata);
    rv_d = rv;
    if (done === 1'b1) dones++;
  end

  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    $display("ERROR watchdog expected end seen hang");
    end_sim();
  end

  initial begin
    rnd_state();
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    en <= 1'b0;
    pulse_start();
    repeat (3) @(negedge clk);
    cmp_bit("busy_no_en", 1'b0, busy);
    @(posedge clk);
    en <= 1'b1;
    base <= 32'h0000_1040;
    pulse_start();
    repeat (4) @(negedge clk);
    cmp_bit("align_err", 1'b1, aerr);
    cmp_bit("busy_refused", 1'b0, busy);
    @(posedge clk);
    run_save({$random(seed)} & 32'hffff_ff00, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    run_save(32'h0004_2300, 1'b1, 1'b1, 1'b1);
    cmp_word("dones", 32'h0000_0002, 32'(dones));
    @(posedge clk);
    for (int n = 0; n < 16; n++) begin
      logic [31:0] t;
      t = $random(seed);
      rn <= t;
      rv <= 1'b1;
      rh <= {3'h0, 6'h22, 11'h0, 4'(n), 2'h0, 6'h2b};
      for (int b = 0; b < 4; b++) begin
        if (!n[b]) rmod[8*b +: 8] = t[8*b +: 8];
      end
      rq.push_back(rmod);
      @(posedge clk);
    end
    rv <= 1'b0;
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule
`default_nettype wire
